// ===== qde_regs.sv
// Purpose: Event flags, event-to-task shortcuts and interrupt enables of the decoder
// Assumes: Event inputs come from the sampling core on i_clk, one-cycle pulses
// Notes:   Task outputs are one-cycle pulses, one clock after the causing event
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Stopped event sets its flag at 0x110; flag reads 0 until then.
// RULE2: Shortcut A: report-ready fires the snapshot-and-clear-both task.
// RULE3: Shortcut B: sample-ready fires the stop task.
// RULE4: Shortcut C: report-ready fires the snapshot-and-clear-motion task.
// RULE5: Shortcut D: report-ready fires the stop task.
// RULE6: Shortcut E: double-ready fires the snapshot-and-clear-doubles task.
// RULE7: Shortcut F: double-ready fires the stop task.
// RULE8: Shortcut G: sample-ready fires the both task; all shortcuts reset off.
// RULE9: Writing 1 to enable-set bit A enables the sample-ready interrupt.
// RULE10: Writing 1 to enable-set bit B enables the report-ready interrupt.
// RULE11: Writing 1 to enable-set bit C enables the overflow interrupt.
// RULE12: Writing 1 to enable-set bit D enables the double-ready interrupt.
// RULE13: Writing 1 to enable-set bit E enables the stopped interrupt.
// RULE14: Enable-set reads current enables; written zeros change nothing.
// RULE15: Report-ready only when period is complete and motion total nonzero.
// RULE16: Double-ready only when period is complete and doubles total nonzero.
// RULE17: Both task snapshots and clears both totals as one atomic step.
// RULE18: Writing 1 to enable-clear disables; it reads like enable-set.
// RULE19: Interrupt is high while an enabled event flag is set.
module qde_regs (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_srst,
   // Wishbone classic slave
   input  wire logic                        i_wb_cyc,
   input  wire logic                        i_wb_stb,
   input  wire logic                        i_wb_we,
   input  wire logic [qde_pkg::ADR_W-1:0]   i_wb_adr,
   input  wire logic [qde_pkg::SEL_W-1:0]   i_wb_sel,
   input  wire logic [qde_pkg::DAT_W-1:0]   i_wb_dat,
   output logic      [qde_pkg::DAT_W-1:0]   o_wb_dat,
   output logic                             o_wb_ack,
   // Sampling core status
   input  wire logic                        i_sample_ready,
   input  wire logic                        i_period_done,
   input  wire logic                        i_motion_nonzero,
   input  wire logic                        i_doubles_nonzero,
   input  wire logic                        i_total_overflow,
   input  wire logic                        i_stopped,
   // Tasks to the sampling core
   output logic                             o_stop_task,
   output logic                             o_snapshot_clear_both_task,
   output logic                             o_snapshot_clear_motion_task,
   output logic                             o_snapshot_clear_doubles_task,
   // Interrupt
   output logic                             o_irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic is_event_ofs(input logic [qde_pkg::ADR_W-1:0] adr,
                                         input int idx);
      logic [qde_pkg::ADR_W-1:0] base;
      base = qde_pkg::OFS_EV_SAMPLE;
      return adr == (base + qde_pkg::ADR_W'(idx * qde_pkg::OFS_EV_STEP));
   endfunction : is_event_ofs

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [qde_pkg::NUM_EV-1:0] ev_flag;
   logic [qde_pkg::NUM_EV-1:0] ev_pulse;
   logic [qde_pkg::NUM_EV-1:0] irq_enable;
   logic [qde_pkg::NUM_EV-1:0] pending;
   logic [qde_pkg::NUM_LK-1:0] links;
   logic                       req;
   logic                       wr;
   logic                       rd;
   logic                       report_ready_event;
   logic                       double_transition_ready_event;
   logic [qde_pkg::DAT_W-1:0]  next_rdata;
   logic                       next_stop;
   logic                       next_both;

   ////////////////////////////////////////////////////////////////////////////////
   // Event generation
   assign report_ready_event            = i_period_done && i_motion_nonzero;   // RULE15
   assign double_transition_ready_event = i_period_done && i_doubles_nonzero;  // RULE16

   always_comb begin
      ev_pulse                      = '0;
      ev_pulse[qde_pkg::EV_SAMPLE]  = i_sample_ready;
      ev_pulse[qde_pkg::EV_REPORT]  = report_ready_event;
      ev_pulse[qde_pkg::EV_OVERFL]  = i_total_overflow;
      ev_pulse[qde_pkg::EV_DOUBLE]  = double_transition_ready_event;
      ev_pulse[qde_pkg::EV_STOPPED] = i_stopped;                               // RULE1
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, ack drops the cycle after it rises
   assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr  = req && i_wb_we && i_wb_sel[0];
   assign rd  = req && !i_wb_we;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= req;
      end
   end

   always_comb begin
      next_rdata = qde_pkg::RST_DAT;
      if (i_wb_adr == qde_pkg::OFS_LINKS) begin
         next_rdata[qde_pkg::NUM_LK-1:0] = links;
      end else if (i_wb_adr == qde_pkg::OFS_IRQ_SET) begin
         next_rdata[qde_pkg::NUM_EV-1:0] = irq_enable;                         // RULE14
      end else if (i_wb_adr == qde_pkg::OFS_IRQ_CLR) begin
         next_rdata[qde_pkg::NUM_EV-1:0] = irq_enable;                         // RULE18
      end else if (i_wb_adr == qde_pkg::OFS_PENDING) begin
         next_rdata[qde_pkg::NUM_EV-1:0] = pending;
      end else begin
         for (int i = 0; i < qde_pkg::NUM_EV; i++) begin
            if (is_event_ofs(i_wb_adr, i)) begin
               next_rdata[0] = ev_flag[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_wb_dat <= qde_pkg::RST_DAT;
      end else if (rd) begin
         o_wb_dat <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event flags: hardware set wins over a software write of 0
   genvar g;
   generate
      for (g = 0; g < qde_pkg::NUM_EV; g++) begin : g_ev
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               ev_flag[g] <= qde_pkg::RST_EV[g];
            end else if (ev_pulse[g]) begin
               ev_flag[g] <= 1'b1;                                             // RULE1
            end else if (wr && is_event_ofs(i_wb_adr, g)) begin
               ev_flag[g] <= i_wb_dat[0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Shortcut register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         links <= qde_pkg::RST_LK;                                             // RULE8
      end else if (wr && i_wb_adr == qde_pkg::OFS_LINKS) begin
         links <= i_wb_dat[qde_pkg::NUM_LK-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt enables: set and clear views of one register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         irq_enable <= qde_pkg::RST_EN;
      end else if (wr && i_wb_adr == qde_pkg::OFS_IRQ_SET) begin
         irq_enable <= irq_enable | i_wb_dat[qde_pkg::NUM_EV-1:0];  // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14
      end else if (wr && i_wb_adr == qde_pkg::OFS_IRQ_CLR) begin
         irq_enable <= irq_enable & ~i_wb_dat[qde_pkg::NUM_EV-1:0];            // RULE18
      end
   end

   // Pending status: cleared by a read, a same-cycle event survives the clear
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pending <= qde_pkg::RST_EV;
      end else if (rd && i_wb_adr == qde_pkg::OFS_PENDING) begin
         pending <= ev_pulse;
      end else begin
         pending <= pending | ev_pulse;
      end
   end

   // Level output; flags keep it up even after the pending view was read
   assign o_irq = |((ev_flag | pending) & irq_enable);                         // RULE19

   ////////////////////////////////////////////////////////////////////////////////
   // Shortcuts to tasks
   always_comb begin
      next_stop = (links[qde_pkg::LK_SAMPLE_STOP] && i_sample_ready)                    // RULE3
               || (links[qde_pkg::LK_REPORT_STOP] && report_ready_event)                // RULE5
               || (links[qde_pkg::LK_DOUBLE_STOP] && double_transition_ready_event);    // RULE7
      next_both = (links[qde_pkg::LK_REPORT_BOTH] && report_ready_event)                // RULE2
               || (links[qde_pkg::LK_SAMPLE_BOTH] && i_sample_ready);                   // RULE8
   end

   // Single both-task pulse: the core copies and clears both totals together
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_stop_task                   <= 1'b0;
         o_snapshot_clear_both_task    <= 1'b0;
         o_snapshot_clear_motion_task  <= 1'b0;
         o_snapshot_clear_doubles_task <= 1'b0;
      end else begin
         o_stop_task                   <= next_stop;
         o_snapshot_clear_both_task    <= next_both;                                     // RULE17
         o_snapshot_clear_motion_task  <= links[qde_pkg::LK_REPORT_MOTION]
                                          && report_ready_event;                         // RULE4
         o_snapshot_clear_doubles_task <= links[qde_pkg::LK_DOUBLE_DBLS]
                                          && double_transition_ready_event;              // RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_write(logic [qde_pkg::ADR_W-1:0] ofs);
      i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && !o_wb_ack && i_wb_adr == ofs;
   endsequence

   sequence s_report_with(int bitpos);
      i_period_done && i_motion_nonzero && links[bitpos];
   endsequence

   // Taken read of one register
   sequence s_read(logic [qde_pkg::ADR_W-1:0] ofs);
      i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == ofs;
   endsequence

   // Any request in the cycle it is taken
   sequence s_taken;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence

   chk_stopped_flag_set: assert property (i_stopped |=> ev_flag[qde_pkg::EV_STOPPED] // RULE1
      ) else $error("stopped flag not set");
   chk_report_both_task: assert property (s_report_with(qde_pkg::LK_REPORT_BOTH) // RULE2
      |=> o_snapshot_clear_both_task) else $error("both task missing after report");
   chk_sample_stop_task: assert property (i_sample_ready && links[qde_pkg::LK_SAMPLE_STOP] // RULE3
      |=> o_stop_task) else $error("stop missing after sample");
   chk_report_motion_task: assert property (s_report_with(qde_pkg::LK_REPORT_MOTION) // RULE4
      |=> o_snapshot_clear_motion_task) else $error("motion task missing");
   chk_report_stop_task: assert property (s_report_with(qde_pkg::LK_REPORT_STOP) // RULE5
      |=> o_stop_task) else $error("stop missing after report");
   chk_double_dbls_task: assert property (i_period_done && i_doubles_nonzero // RULE6
      && links[qde_pkg::LK_DOUBLE_DBLS] |=> o_snapshot_clear_doubles_task)
      else $error("doubles task missing");
   chk_double_stop_task: assert property (i_period_done && i_doubles_nonzero // RULE7
      && links[qde_pkg::LK_DOUBLE_STOP] |=> o_stop_task) else $error("stop missing after double");
   chk_sample_both_task: assert property (i_sample_ready && links[qde_pkg::LK_SAMPLE_BOTH] // RULE8
      |=> o_snapshot_clear_both_task) else $error("both task missing after sample");
   chk_enable_set_bits: assert property (s_write(qde_pkg::OFS_IRQ_SET) // RULE9 RULE10 RULE11 RULE12 RULE13
      |=> (irq_enable & $past(i_wb_dat[qde_pkg::NUM_EV-1:0]))
          == $past(i_wb_dat[qde_pkg::NUM_EV-1:0])) else $error("enable set lost");
   chk_enable_zero_hold: assert property (s_write(qde_pkg::OFS_IRQ_SET) // RULE14
      |=> (irq_enable & $past(irq_enable)) == $past(irq_enable)) else $error("enable dropped");
   chk_motion_task_cause: assert property (o_snapshot_clear_motion_task // RULE15
      |-> $past(i_period_done) && $past(i_motion_nonzero)) else $error("report without motion");
   chk_doubles_task_cause: assert property (o_snapshot_clear_doubles_task // RULE16
      |-> $past(i_period_done) && $past(i_doubles_nonzero)) else $error("double without count");
   chk_enable_clear_bits: assert property (s_write(qde_pkg::OFS_IRQ_CLR) // RULE18
      |=> (irq_enable & $past(i_wb_dat[qde_pkg::NUM_EV-1:0])) == '0) else $error("clear failed");
   chk_irq_level: assert property ((ev_flag & irq_enable) != '0 |-> o_irq // RULE19
      ) else $error("irq low with enabled flag");
   chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
   chk_ack_after_req: assert property (
      s_taken
      |=> o_wb_ack)
      else $error("request not acked");
   chk_ack_has_cause: assert property (
      o_wb_ack
      |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");

   ////////////////////////////////////////////////////////////////////////////////
   // Task causes: a pulse needs an enabled shortcut and its event
   chk_both_task_cause: assert property (  // RULE17
      o_snapshot_clear_both_task
      |-> $past(i_period_done && i_motion_nonzero && links[qde_pkg::LK_REPORT_BOTH])
          || $past(i_sample_ready && links[qde_pkg::LK_SAMPLE_BOTH]))
      else $error("spurious both task");
   chk_stop_task_cause: assert property (  // RULE3 RULE5 RULE7
      o_stop_task
      |-> $past(i_sample_ready && links[qde_pkg::LK_SAMPLE_STOP])
          || $past(i_period_done && i_motion_nonzero && links[qde_pkg::LK_REPORT_STOP])
          || $past(i_period_done && i_doubles_nonzero && links[qde_pkg::LK_DOUBLE_STOP]))
      else $error("spurious stop task");
   chk_stop_task_off: assert property (  // RULE3 RULE5 RULE7
      !links[qde_pkg::LK_SAMPLE_STOP] && !links[qde_pkg::LK_REPORT_STOP]
      && !links[qde_pkg::LK_DOUBLE_STOP]
      |=> !o_stop_task)
      else $error("stop task with shortcuts off");
   chk_both_task_off: assert property (  // RULE2 RULE8
      !links[qde_pkg::LK_REPORT_BOTH] && !links[qde_pkg::LK_SAMPLE_BOTH]
      |=> !o_snapshot_clear_both_task)
      else $error("both task with shortcuts off");
   chk_motion_task_off: assert property (  // RULE4
      !links[qde_pkg::LK_REPORT_MOTION]
      |=> !o_snapshot_clear_motion_task)
      else $error("motion task with shortcut off");
   chk_doubles_task_off: assert property (  // RULE6
      !links[qde_pkg::LK_DOUBLE_DBLS]
      |=> !o_snapshot_clear_doubles_task)
      else $error("doubles task with shortcut off");

   ////////////////////////////////////////////////////////////////////////////////
   // Event flags: set by their own event or by a written 1, sticky until written
   chk_stopped_flag_hold: assert property (  // RULE1
      ev_flag[qde_pkg::EV_STOPPED] && !wr
      |=> ev_flag[qde_pkg::EV_STOPPED])
      else $error("stopped flag lost");
   chk_stopped_flag_quiet: assert property (  // RULE1
      !ev_flag[qde_pkg::EV_STOPPED] && !i_stopped && !wr
      |=> !ev_flag[qde_pkg::EV_STOPPED])
      else $error("stopped flag without event");
   chk_report_flag_set: assert property (  // RULE15
      i_period_done && i_motion_nonzero
      |=> ev_flag[qde_pkg::EV_REPORT])
      else $error("report flag not set");
   chk_report_needs_motion: assert property (  // RULE15
      !ev_flag[qde_pkg::EV_REPORT] && !wr && !(i_period_done && i_motion_nonzero)
      |=> !ev_flag[qde_pkg::EV_REPORT])
      else $error("report flag without motion");
   chk_double_flag_set: assert property (  // RULE16
      i_period_done && i_doubles_nonzero
      |=> ev_flag[qde_pkg::EV_DOUBLE])
      else $error("double flag not set");
   chk_double_needs_count: assert property (  // RULE16
      !ev_flag[qde_pkg::EV_DOUBLE] && !wr && !(i_period_done && i_doubles_nonzero)
      |=> !ev_flag[qde_pkg::EV_DOUBLE])
      else $error("double flag without count");
   chk_sample_flag_set: assert property (
      i_sample_ready
      |=> ev_flag[qde_pkg::EV_SAMPLE])
      else $error("sample flag not set");
   chk_overflow_flag_set: assert property (
      i_total_overflow
      |=> ev_flag[qde_pkg::EV_OVERFL])
      else $error("overflow flag not set");

   ////////////////////////////////////////////////////////////////////////////////
   // Registers: change only on a taken write, read back as stored
   chk_links_write: assert property (  // RULE8
      s_write(qde_pkg::OFS_LINKS)
      |=> links == $past(i_wb_dat[qde_pkg::NUM_LK-1:0]))
      else $error("shortcut write lost");
   chk_links_hold: assert property (  // RULE8
      !wr
      |=> $stable(links))
      else $error("shortcuts changed without write");
   chk_enable_hold: assert property (  // RULE14 RULE18
      !wr
      |=> $stable(irq_enable))
      else $error("enables changed without write");
   chk_enable_set_read: assert property (  // RULE14
      s_read(qde_pkg::OFS_IRQ_SET)
      |=> o_wb_ack && o_wb_dat == qde_pkg::DAT_W'($past(irq_enable)))
      else $error("enable set read wrong");
   chk_enable_clr_read: assert property (  // RULE18
      s_read(qde_pkg::OFS_IRQ_CLR)
      |=> o_wb_ack && o_wb_dat == qde_pkg::DAT_W'($past(irq_enable)))
      else $error("enable clear read wrong");

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt and pending status
   chk_irq_quiet: assert property (  // RULE19
      irq_enable == '0
      |-> !o_irq)
      else $error("irq with all enables off");
   chk_pending_read_clear: assert property (
      s_read(qde_pkg::OFS_PENDING)
      |=> o_wb_dat == qde_pkg::DAT_W'($past(pending)) && (pending & ~$past(ev_pulse)) == '0)
      else $error("pending read did not clear");

endmodule : qde_regs
`default_nettype wire

// ===== qde_pkg.sv
// Purpose: Shared constants for the quadrature decoder event, shortcut and interrupt bank
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   All offsets are byte addresses of aligned words
`default_nettype none
package qde_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int ADR_W  = 12;
   localparam int DAT_W  = 32;
   localparam int SEL_W  = 4;
   localparam int NUM_EV = 5;
   localparam int NUM_LK = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [ADR_W-1:0] OFS_EV_SAMPLE  = 12'h100;
   localparam logic [ADR_W-1:0] OFS_EV_REPORT  = 12'h104;
   localparam logic [ADR_W-1:0] OFS_EV_OVERFL  = 12'h108;
   localparam logic [ADR_W-1:0] OFS_EV_DOUBLE  = 12'h10C;
   localparam logic [ADR_W-1:0] OFS_EV_STOPPED = 12'h110;
   localparam logic [ADR_W-1:0] OFS_LINKS      = 12'h200;
   localparam logic [ADR_W-1:0] OFS_IRQ_SET    = 12'h304;
   localparam logic [ADR_W-1:0] OFS_IRQ_CLR    = 12'h308;
   localparam logic [ADR_W-1:0] OFS_PENDING    = 12'h400;
   // Spacing of the event flag words
   localparam int               OFS_EV_STEP    = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Event bit positions, shared by flags, enables and pending status
   localparam int EV_SAMPLE  = 0;
   localparam int EV_REPORT  = 1;
   localparam int EV_OVERFL  = 2;
   localparam int EV_DOUBLE  = 3;
   localparam int EV_STOPPED = 4;

   // Shortcut bit positions in event_task_links
   localparam int LK_REPORT_BOTH   = 0;
   localparam int LK_SAMPLE_STOP   = 1;
   localparam int LK_REPORT_MOTION = 2;
   localparam int LK_REPORT_STOP   = 3;
   localparam int LK_DOUBLE_DBLS   = 4;
   localparam int LK_DOUBLE_STOP   = 5;
   localparam int LK_SAMPLE_BOTH   = 6;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [NUM_EV-1:0] RST_EV    = 5'h00;
   localparam logic [NUM_LK-1:0] RST_LK    = 7'h00;
   localparam logic [NUM_EV-1:0] RST_EN    = 5'h00;
   localparam logic [DAT_W-1:0]  RST_DAT   = 32'h00000000;
endpackage : qde_pkg
`default_nettype wire

// ===== qde_testbench.sv
// Purpose: Self-checking bench for the decoder event, shortcut and interrupt bank
// Assumes: Registered one-cycle ack, task pulses one clock after their event
// Notes:   Shortcut cases run from a table; reset, enables and odd cases by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
   ////////////////////////////////////////////////////////////////////////////////
   // Rows: links[14:8], {sample,period,motion,doubles}[7:4], {stop,both,motion,dbls}[3:0]
   localparam logic [14:0] ROWS [11] = '{15'h0164, 15'h0288, 15'h0462, 15'h0868,
      15'h1051, 15'h2058, 15'h4084, 15'h7F40, 15'h00F0, 15'h1060, 15'h2AF8};
   // Event inputs {sample,period,motion,doubles,overflow,stopped} per enable bit
   localparam logic [5:0]  EVS [5] = '{6'h20, 6'h18, 6'h02, 6'h14, 6'h01};

   logic        i_clk;
   logic        i_srst, cyc, stb, we;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, o_wb_dat, rd;
   logic        o_wb_ack, samp, per, mot, dbl, ovf, stp;
   logic        stop_t, both_t, mot_t, dbl_t, o_irq;
   int          n_mismatch;
   int          num_checks;

   qde_regs qde_regs_inst (.i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .i_sample_ready(samp), .i_period_done(per),
      .i_motion_nonzero(mot), .i_doubles_nonzero(dbl), .i_total_overflow(ovf),
      .i_stopped(stp), .o_stop_task(stop_t), .o_snapshot_clear_both_task(both_t),
      .o_snapshot_clear_motion_task(mot_t), .o_snapshot_clear_doubles_task(dbl_t),
      .o_irq(o_irq));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_w

   task automatic chk_s(input logic [3:0] got, input logic [3:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_s

   // Holds the request until ack is sampled high, then releases for one idle cycle
   // No cap on the wait: a hung bus is ended by the watchdog
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
      end while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      wb(1'b0, a, 32'h00000000);
      chk_w(rd, exp, what);
   endtask : rd_chk

   // One-cycle event pulse, then the edge where registered results are visible
   task automatic pulse(input logic [5:0] ev);
      @(posedge i_clk);
      {samp, per, mot, dbl, ovf, stp} <= ev;
      @(posedge i_clk);
      {samp, per, mot, dbl, ovf, stp} <= 6'h00;
      @(posedge i_clk);
   endtask : pulse

   task automatic do_reset;
      i_srst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {i_srst, cyc, stb, we, samp, per, mot, dbl, ovf, stp} = 10'h200;
      adr = 12'h000; sel = 4'hF; wdat = 32'h00000000;
      n_mismatch = 0; num_checks = 0;
      do_reset();
      foreach (ROWS[r]) begin
         wb(1'b1, qde_pkg::OFS_LINKS, {25'h0, ROWS[r][14:8]});
         rd_chk(qde_pkg::OFS_LINKS, {25'h0, ROWS[r][14:8]}, "links readback");
         pulse({ROWS[r][7:4], 2'b00});
         chk_s({stop_t, both_t, mot_t, dbl_t}, ROWS[r][3:0], "task pulses");
      end
      $display("test shortcut table done");
      // Events above left flags set; reset must wipe them
      do_reset();
      rd_chk(qde_pkg::OFS_EV_STOPPED, 32'h00000000, "stopped flag at reset");
      rd_chk(qde_pkg::OFS_LINKS, 32'h00000000, "links at reset");
      rd_chk(qde_pkg::OFS_IRQ_SET, 32'h00000000, "enables at reset");
      chk_s({3'h0, o_irq}, 4'h0, "irq at reset");
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, qde_pkg::OFS_IRQ_SET, 32'h1 << i);
         wb(1'b1, qde_pkg::OFS_IRQ_SET, 32'h00000000);
         rd_chk(qde_pkg::OFS_IRQ_SET, 32'h1 << i, "enable set readback");
         chk_s({3'h0, o_irq}, 4'h0, "irq before event");
         pulse(EVS[i]);
         chk_s({3'h0, o_irq}, 4'h1, "irq after event");
         wb(1'b1, qde_pkg::OFS_IRQ_CLR, 32'h1 << i);
         chk_s({3'h0, o_irq}, 4'h0, "irq after disable");
         rd_chk(qde_pkg::OFS_IRQ_CLR, 32'h00000000, "enable clear readback");
      end
      $display("test interrupt enables done");
      rd_chk(qde_pkg::OFS_EV_STOPPED, 32'h00000001, "stopped flag set");
      rd_chk(qde_pkg::OFS_EV_REPORT, 32'h00000001, "report flag set");
      rd_chk(qde_pkg::OFS_EV_DOUBLE, 32'h00000001, "double flag set");
      rd_chk(qde_pkg::OFS_PENDING, 32'h0000001F, "pending after events");
      rd_chk(qde_pkg::OFS_PENDING, 32'h00000000, "pending after read");
      wb(1'b1, qde_pkg::OFS_EV_STOPPED, 32'h00000000);
      rd_chk(qde_pkg::OFS_EV_STOPPED, 32'h00000000, "stopped flag cleared");
      wb(1'b1, qde_pkg::OFS_LINKS, 32'hFFFFFFFF);
      rd_chk(qde_pkg::OFS_LINKS, 32'h0000007F, "links upper bits");
      wb(1'b1, 12'h7FC, 32'hFFFFFFFF);
      rd_chk(12'h7FC, 32'h00000000, "unmapped read");
      $display("test odd cases done");
      end_of_test();
   end

   // Whole run is a few hundred cycles; this span is far beyond it
   initial begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      $display("mismatch at %0t: run did not finish", $time);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
